// ### seao_params.svh
// Purpose: constants for the switch event alert output block
// Assumes: 25 MHz mclk
// Notes:   interval counts are defaults of top-level parameters
`ifndef SEAO_PARAMS_SVH
`define SEAO_PARAMS_SVH

`define SEAO_CLK_MHZ          25
`define SEAO_ACTIVE_US        1000
`define SEAO_INACTIVE_US      1000
`define SEAO_IDLE_US          100
`define SEAO_ACTIVE_CYC       (`SEAO_ACTIVE_US * `SEAO_CLK_MHZ)
`define SEAO_INACTIVE_CYC     (`SEAO_INACTIVE_US * `SEAO_CLK_MHZ)
`define SEAO_IDLE_CYC         (`SEAO_IDLE_US * `SEAO_CLK_MHZ)
`define SEAO_NUM_INPUTS       24
`define SEAO_NUM_SHARED       12
`define SEAO_EDGE_OFF         2'h0
`define SEAO_EDGE_RISE        2'h1
`define SEAO_EDGE_FALL        2'h2
`define SEAO_EDGE_BOTH        2'h3
`define SEAO_SCHEME_STATIC    1'b0
`define SEAO_SCHEME_DYNAMIC   1'b1

`endif

// ### seao_pkg.sv
// Purpose: shared types of the switch event alert output block
// Assumes: constants live in seao_params.svh
// Notes:   none
`default_nettype none
package seao_pkg;
    typedef enum logic [1:0] {
        SEAO_IDLE_ST = 2'b00,
        SEAO_LOW_ST  = 2'b01,
        SEAO_HIGH_ST = 2'b10,
        SEAO_WAIT_ST = 2'b11
    } seao_state_type;

    typedef struct packed {
        logic cs_rise;
        logic sclk_first;
        logic flag_read;
    } seao_spi_ev_type;
endpackage
`default_nettype wire

// ### seao_edge_detect.sv
// Purpose: per-input threshold crossing detection with edge qualification
// Assumes: sample_valid marks a new measurement on the same clock
// Notes:   first sample after reset only stores state
`timescale 1ns/10ps
`default_nettype none
`include "seao_params.svh"
module seao_edge_detect #(
    parameter int N = 24
) (
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    // measurements
    input  wire logic           sample_valid,
    input  wire logic [N-1:0]   above,
    input  wire logic [2*N-1:0] edge_sel,
    // events
    output logic      [N-1:0]   crossing
);
    logic [N-1:0] prev;
    logic         primed;

    function automatic logic qualify(input logic [1:0] sel, input logic cur, input logic old);
        qualify = 1'b0;
        case (sel)
            `SEAO_EDGE_RISE: qualify = cur & ~old;
            `SEAO_EDGE_FALL: qualify = ~cur & old;
            `SEAO_EDGE_BOTH: qualify = cur ^ old;
            default:         qualify = 1'b0;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev   <= '0;
            primed <= 1'b0;
        end else if (sample_valid) begin
            prev   <= above;
            primed <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_in
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    crossing[i] <= 1'b0;
                end else begin
                    crossing[i] <= sample_valid & primed & qualify(edge_sel[2*i+1:2*i], above[i], prev[i]);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### seao_spi_watch.sv
// Purpose: watches chip select and SCLK for event flag capture and clearing reads
// Assumes: pins synchronised here on mclk
// Notes:   read_cmd is a level from the SPI decoder, valid before CS rises
`timescale 1ns/10ps
`default_nettype none
module seao_spi_watch (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // pins
    input  wire logic              cs_n_pin,
    input  wire logic              sclk_pin,
    // decoder
    input  wire logic              flag_read_cmd,
    // events
    output seao_pkg::seao_spi_ev_type ev
);
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic       cs_d;
    logic       sclk_d;
    logic       armed;
    logic       read_seen;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync   <= 2'h3;
            sclk_sync <= 2'h0;
            cs_d      <= 1'b1;
            sclk_d    <= 1'b0;
        end else begin
            cs_sync   <= {cs_sync[0], cs_n_pin};
            sclk_sync <= {sclk_sync[0], sclk_pin};
            cs_d      <= cs_sync[1];
            sclk_d    <= sclk_sync[1];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            armed     <= 1'b0;
            read_seen <= 1'b0;
            ev        <= '0;
        end else begin
            ev.cs_rise    <= cs_sync[1] & ~cs_d;
            ev.flag_read  <= cs_sync[1] & ~cs_d & (read_seen | flag_read_cmd);
            ev.sclk_first <= armed & ~cs_sync[1] & sclk_sync[1] & ~sclk_d;
            if (cs_d & ~cs_sync[1]) begin
                armed     <= 1'b1;
                read_seen <= 1'b0;
            end else if (armed & sclk_sync[1] & ~sclk_d) begin
                armed <= 1'b0;
            end
            if (~cs_sync[1] & flag_read_cmd) begin
                read_seen <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### seao_alert.sv
// Purpose: alert pin control with static and dynamic schemes and idle time
// Assumes: warnings arrive as levels on mclk, their rise is the event; host keeps its own regulator
// Notes:   alert pin is open drain: oe low pulls low, otherwise released
`timescale 1ns/10ps
`default_nettype none
`include "seao_params.svh"
module seao_alert #(
    parameter int ACTIVE_CYC   = `SEAO_ACTIVE_CYC,
    parameter int INACTIVE_CYC = `SEAO_INACTIVE_CYC,
    parameter int IDLE_CYC     = `SEAO_IDLE_CYC,
    parameter int N            = `SEAO_NUM_INPUTS,
    parameter int NS           = `SEAO_NUM_SHARED
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            reset_n,
    // configuration
    input  wire logic            scheme_sel,
    input  wire logic            trigger,
    input  wire logic [N-1:0]    adc_mode,
    input  wire logic [2*N-1:0]  comparator_event_enable,
    input  wire logic [2*N-1:0]  adc_event_enable,
    input  wire logic [2*NS-1:0] shared_limit_event_enable,
    // measurements
    input  wire logic            sample_valid,
    input  wire logic [N-1:0]    above,
    input  wire logic [NS-1:0]   above_shared,
    input  wire logic            temp_warn,
    input  wire logic            over_volt,
    // spi pins and decoder
    input  wire logic            cs_n_pin,
    input  wire logic            sclk_pin,
    input  wire logic            flag_read_cmd,
    // status
    output logic [N+NS+1:0]      event_flags,
    output logic [N+NS+1:0]      flags_snapshot,
    output logic                 scheme_active,
    // alert pin
    output logic                 alert_out,
    output logic                 alert_oe_n
);
    localparam int W  = N + NS + 2;
    localparam int CW = 32;

    logic [1:0]                 rst_sync;
    logic                       rst_n;
    logic [2*N-1:0]             edge_sel;
    logic [N-1:0]               cross_in;
    logic [NS-1:0]              cross_sh;
    logic [W-1:0]               new_ev;
    logic                       tw_d;
    logic                       ov_d;
    seao_pkg::seao_spi_ev_type  spi_ev;
    seao_pkg::seao_state_type   state;
    logic [CW-1:0]              count;
    logic                       pending;
    logic                       dyn;
    logic [1:0]                 warn_rise;
    logic [W-1:0]               remain;
    logic                       next_alert_oe_n;

    // a stretch of len cycles has run out once the counter holds len - 1
    function automatic logic reached(input logic [CW-1:0] cnt, input int len);
        reached = (cnt >= CW'(len - 1));
    endfunction

    // reset release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // per-input edge selection from the enable set of the input mode
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_sel
            assign edge_sel[2*i+1:2*i] = adc_mode[i] ? adc_event_enable[2*i+1:2*i]
                                                     : comparator_event_enable[2*i+1:2*i];
        end
    endgenerate

    seao_edge_detect #(.N(N)) u_in (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .above        (above),
        .edge_sel     (edge_sel),
        .crossing     (cross_in)
    );

    seao_edge_detect #(.N(NS)) u_sh (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .above        (above_shared),
        .edge_sel     (shared_limit_event_enable),
        .crossing     (cross_sh)
    );

    seao_spi_watch u_spi (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .cs_n_pin      (cs_n_pin),
        .sclk_pin      (sclk_pin),
        .flag_read_cmd (flag_read_cmd),
        .ev            (spi_ev)
    );

    // warning events on rising level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tw_d <= 1'b0;
            ov_d <= 1'b0;
        end else begin
            tw_d <= temp_warn;
            ov_d <= over_volt;
        end
    end
    assign warn_rise = {over_volt & ~ov_d, temp_warn & ~tw_d};
    assign new_ev    = {warn_rise, cross_sh, cross_in};

    // scheme bit, static after reset, frozen while triggered
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scheme_active <= `SEAO_SCHEME_STATIC;
        end else if (!trigger) begin
            scheme_active <= scheme_sel;
        end
    end

    // dynamic toggling selected
    assign dyn = (scheme_active == `SEAO_SCHEME_DYNAMIC);

    // a flag read clears only what the host was shown, later events stay
    assign remain = event_flags & ~flags_snapshot;

    // event flags: set wins over clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_flags <= '0;
        end else if (spi_ev.flag_read) begin
            event_flags <= remain | new_ev;
        end else begin
            event_flags <= event_flags | new_ev;
        end
    end

    // snapshot at first SCLK rise of each transaction
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_snapshot <= '0;
        end else if (spi_ev.sclk_first) begin
            flags_snapshot <= event_flags;
        end
    end

    // an event is waiting to be signalled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (spi_ev.flag_read) begin
            pending <= |(remain | new_ev);
        end else if (|new_ev) begin
            pending <= 1'b1;
        end
    end

    // alert sequencing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= seao_pkg::SEAO_IDLE_ST;
            count <= '0;
        end else begin
            case (state)
                seao_pkg::SEAO_IDLE_ST: begin
                    if (pending && !spi_ev.flag_read) begin
                        state <= seao_pkg::SEAO_LOW_ST;
                        count <= '0;
                    end
                end
                seao_pkg::SEAO_LOW_ST: begin
                    if (spi_ev.flag_read) begin
                        state <= seao_pkg::SEAO_WAIT_ST;
                        count <= '0;
                    end else if (dyn) begin
                        if (reached(count, ACTIVE_CYC)) begin
                            state <= seao_pkg::SEAO_HIGH_ST;
                            count <= '0;
                        end else begin
                            count <= count + 1'b1;
                        end
                    end
                end
                seao_pkg::SEAO_HIGH_ST: begin
                    if (spi_ev.flag_read) begin
                        state <= seao_pkg::SEAO_WAIT_ST;
                        count <= '0;
                    end else if (reached(count, INACTIVE_CYC)) begin
                        state <= seao_pkg::SEAO_LOW_ST;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                seao_pkg::SEAO_WAIT_ST: begin
                    if (spi_ev.flag_read) begin
                        count <= '0;
                    end else if (reached(count, IDLE_CYC)) begin
                        state <= pending ? seao_pkg::SEAO_LOW_ST
                                         : seao_pkg::SEAO_IDLE_ST;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: begin
                    state <= seao_pkg::SEAO_IDLE_ST;
                    count <= '0;
                end
            endcase
        end
    end

    // pin drive for the next cycle, mirrors the state moves above
    always_comb begin
        next_alert_oe_n = 1'b1;
        case (state)
            seao_pkg::SEAO_IDLE_ST: begin
                if (pending && !spi_ev.flag_read) begin
                    next_alert_oe_n = 1'b0;
                end
            end
            seao_pkg::SEAO_LOW_ST: begin
                if (spi_ev.flag_read) begin
                    next_alert_oe_n = 1'b1;
                end else if (dyn && reached(count, ACTIVE_CYC)) begin
                    next_alert_oe_n = 1'b1;
                end else begin
                    next_alert_oe_n = 1'b0;
                end
            end
            seao_pkg::SEAO_HIGH_ST: begin
                if (!spi_ev.flag_read && reached(count, INACTIVE_CYC)) begin
                    next_alert_oe_n = 1'b0;
                end
            end
            seao_pkg::SEAO_WAIT_ST: begin
                if (!spi_ev.flag_read && pending && reached(count, IDLE_CYC)) begin
                    next_alert_oe_n = 1'b0;
                end
            end
            default: begin
                next_alert_oe_n = 1'b1;
            end
        endcase
    end

    // the pin is never driven high, only pulled low or released
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alert_out <= 1'b0;
        end else begin
            alert_out <= 1'b0;
        end
    end

    // open drain drive: oe low pulls the pin low, oe high releases it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alert_oe_n <= 1'b1;
        end else begin
            alert_oe_n <= next_alert_oe_n;
        end
    end
endmodule
`default_nettype wire

// ### seao_alert_sva.sv
// Purpose: checker for the alert output block
// Assumes: sees only the top module ports
// Notes:   bound to seao_alert below
`timescale 1ns/10ps
`default_nettype none
module seao_alert_sva #(
    parameter int ACTIVE_CYC   = 20,
    parameter int INACTIVE_CYC = 20,
    parameter int IDLE_CYC     = 10,
    parameter int N            = 24,
    parameter int NS           = 12
) (
    // clock and reset
    input wire logic            mclk,
    input wire logic            reset_n,
    // configuration and events
    input wire logic            scheme_sel,
    input wire logic            trigger,
    input wire logic            temp_warn,
    input wire logic            over_volt,
    input wire logic            cs_n_pin,
    input wire logic            flag_read_cmd,
    // status and pin
    input wire logic [N+NS+1:0] event_flags,
    input wire logic [N+NS+1:0] flags_snapshot,
    input wire logic            scheme_active,
    input wire logic            alert_out,
    input wire logic            alert_oe_n
);
    logic [15:0] cs_hi;
    logic [15:0] lo_cnt;
    logic [15:0] hi_cnt;

    // cycles since chip select went high
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) cs_hi <= 16'h0;
        else if (!cs_n_pin) cs_hi <= 16'h0;
        else if (cs_hi != 16'hffff) cs_hi <= cs_hi + 16'h1;
    end

    // length of the present low or high stretch of the pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lo_cnt <= 16'h0;
            hi_cnt <= 16'h0;
        end else begin
            lo_cnt <= alert_oe_n ? 16'h0 : lo_cnt + 16'h1;
            hi_cnt <= (!alert_oe_n) ? 16'h0 : (hi_cnt == 16'hffff) ? hi_cnt : hi_cnt + 16'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_reset_quiet: assert property (
        $rose(reset_n) |-> alert_oe_n && event_flags == '0 && !scheme_active)
        else $error("state not cleared by reset");
    a_pin_level: assert property (alert_out == 1'b0)
        else $error("alert pin driven high");
    a_scheme_keep: assert property (
        trigger && $past(trigger) |-> $stable(scheme_active))
        else $error("scheme changed while triggered");
    a_scheme_take: assert property (
        (!trigger && $stable(scheme_sel)) [*5] |-> scheme_active == scheme_sel)
        else $error("scheme select not taken");
    a_read_clear: assert property (
        $rose(cs_n_pin) && $past(flag_read_cmd) |-> ##[1:8] (event_flags & flags_snapshot) == '0)
        else $error("flags not cleared by read");
    a_read_release: assert property (
        $rose(cs_n_pin) && $past(flag_read_cmd) && !alert_oe_n |-> ##[1:8] alert_oe_n)
        else $error("alert not released by read");
    a_static_hold: assert property (
        !scheme_active && !alert_oe_n && cs_hi > 16'd10 |=> !alert_oe_n)
        else $error("static alert released without read");
    a_idle_quiet: assert property ($rose(alert_oe_n) |=> alert_oe_n [*8])
        else $error("alert reasserted too soon");
    a_dyn_low: assert property (scheme_active |-> lo_cnt <= ACTIVE_CYC + 2)
        else $error("dynamic low stretch too long");
    a_flag_set: assert property ($rose(over_volt) |-> ##[1:3] event_flags[N+NS+1])
        else $error("event not flagged");
    a_event_alert: assert property (
        $rose(temp_warn) && hi_cnt > 16'd300 |-> ##[1:3] !alert_oe_n)
        else $error("event did not assert alert");
endmodule

bind seao_alert seao_alert_sva #(.ACTIVE_CYC(ACTIVE_CYC), .INACTIVE_CYC(INACTIVE_CYC),
    .IDLE_CYC(IDLE_CYC), .N(N), .NS(NS)) seao_alert_sva_i (.mclk, .reset_n, .scheme_sel,
    .trigger, .temp_warn, .over_volt, .cs_n_pin, .flag_read_cmd, .event_flags,
    .flags_snapshot, .scheme_active, .alert_out, .alert_oe_n);
`default_nettype wire

// ### seao_host.sv
// Purpose: host model driving chip select, serial clock and read decode
// Assumes: serial clock period 320 ns, still outside frames
// Notes:   hold sets how slowly the host ends a frame
`timescale 1ns/10ps
`default_nettype none
module seao_host (
    // clock
    input  wire logic mclk,
    // spi side
    output logic      cs_n_pin,
    output logic      sclk_pin,
    output logic      flag_read_cmd,
    output logic      regulator_on
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        flag_read_cmd = 1'b0;
        regulator_on = 1'b0;
    end

    // one frame; static scheme assumed for wake-up use
    task automatic xfer(input logic rd, input int hold);
        int i;
        @(negedge mclk);
        regulator_on = 1'b1;
        cs_n_pin = 1'b0;
        flag_read_cmd = rd;
        repeat (4) @(negedge mclk);
        for (i = 0; i < 4; i++) begin
            sclk_pin = ~sclk_pin;
            repeat (4) @(negedge mclk);
        end
        repeat (hold) @(negedge mclk);
        cs_n_pin = 1'b1;
        @(negedge mclk);
        flag_read_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### switch_event_alert_output_tb.sv
// Purpose: testbench for the alert output block
// Assumes: shortened interval counts
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module switch_event_alert_output_tb;
    localparam int ACT = 100;
    localparam int INACT = 100;
    localparam int IDLE = 60;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        scheme_sel = 1'b0;
    logic        trigger = 1'b0;
    logic [23:0] adc_mode = 24'h2;
    logic [47:0] comparator_event_enable = 48'h0;
    logic [47:0] adc_event_enable = 48'h0;
    logic [23:0] shared_limit_event_enable = 24'h0;
    logic        sample_valid = 1'b0;
    logic [23:0] above = 24'h0;
    logic [11:0] above_shared = 12'h0;
    logic        temp_warn = 1'b0;
    logic        over_volt = 1'b0;
    wire logic   cs_n_pin, sclk_pin, flag_read_cmd, regulator_on;
    wire logic   scheme_active, alert_out, alert_oe_n;
    wire logic [37:0] event_flags, flags_snapshot;
    wire logic   alert_pin = alert_oe_n ? 1'b1 : alert_out;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cnt;
    int          m;

    always #20 mclk = ~mclk;

    seao_alert #(.ACTIVE_CYC(ACT), .INACTIVE_CYC(INACT), .IDLE_CYC(IDLE)) seao_alert_i (
        .mclk, .reset_n, .scheme_sel, .trigger, .adc_mode, .comparator_event_enable,
        .adc_event_enable, .shared_limit_event_enable, .sample_valid, .above, .above_shared,
        .temp_warn, .over_volt, .cs_n_pin, .sclk_pin, .flag_read_cmd, .event_flags,
        .flags_snapshot, .scheme_active, .alert_out, .alert_oe_n);
    seao_host seao_host_i (.mclk, .cs_n_pin, .sclk_pin, .flag_read_cmd, .regulator_on);

    task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // waits for a pin level, cnt holds the cycles taken
    task automatic wait_pin(input logic lvl, input int lim);
        cnt = 0;
        while (alert_pin !== lvl && cnt < lim) begin
            cyc(1);
            cnt++;
        end
        chk("alert_pin", {37'h0, lvl}, {37'h0, alert_pin});
    endtask
    task automatic rd(input logic f);
        seao_host_i.xfer(f, 2);
        cyc(6);
    endtask
    task automatic evt(input logic ov);
        if (ov) over_volt = 1'b1;
        else temp_warn = 1'b1;
        cyc(2);
        over_volt = 1'b0;
        temp_warn = 1'b0;
    endtask
    task automatic smp(input logic a);
        above = {24{a}};
        above_shared = {12{a}};
        sample_valid = 1'b1;
        cyc(1);
        sample_valid = 1'b0;
        cyc(4);
    endtask

    initial begin
        cyc(3);
        reset_n = 1'b1;
        cyc(3);
        chk("alert_oe_n", 38'h1, {37'h0, alert_oe_n});
        chk("event_flags", 38'h0, event_flags);
        chk("scheme_active", 38'h0, {37'h0, scheme_active});
        $display("test reset done");
        cyc(320);
        evt(1'b0);
        wait_pin(1'b0, 4);
        rd(1'b0);
        chk("alert_pin", 38'h0, {37'h0, alert_pin});
        chk("flags_snapshot", 38'h1000000000, flags_snapshot);
        chk("regulator_on", 38'h1, {37'h0, regulator_on});
        rd(1'b1);
        chk("alert_pin", 38'h1, {37'h0, alert_pin});
        chk("event_flags", 38'h0, event_flags);
        evt(1'b1);
        chk("event_flags", 38'h2000000000, event_flags);
        cyc(30);
        chk("alert_pin", 38'h1, {37'h0, alert_pin});
        wait_pin(1'b0, 40);
        rd(1'b1);
        evt(1'b0);
        rd(1'b1);
        chk("event_flags", 38'h0, event_flags);
        cyc(80);
        chk("alert_pin", 38'h1, {37'h0, alert_pin});
        $display("test static done");
        scheme_sel = 1'b1;
        cyc(3);
        chk("scheme_active", 38'h1, {37'h0, scheme_active});
        trigger = 1'b1;
        scheme_sel = 1'b0;
        cyc(5);
        chk("scheme_active", 38'h1, {37'h0, scheme_active});
        evt(1'b1);
        wait_pin(1'b0, 4);
        wait_pin(1'b1, ACT + 5);
        chk("active_time", 38'h1, {37'h0, cnt >= ACT - 4 && cnt <= ACT + 1});
        wait_pin(1'b0, INACT + 5);
        chk("inactive_time", 38'h1, {37'h0, cnt >= INACT - 2 && cnt <= INACT + 2});
        cyc(10);
        rd(1'b1);
        chk("alert_pin", 38'h1, {37'h0, alert_pin});
        chk("event_flags", 38'h0, event_flags);
        cyc(IDLE);
        evt(1'b0);
        wait_pin(1'b0, 4);
        wait_pin(1'b1, ACT + 5);
        cyc(10);
        rd(1'b1);
        chk("event_flags", 38'h0, event_flags);
        cyc(300);
        chk("alert_pin", 38'h1, {37'h0, alert_pin});
        trigger = 1'b0;
        cyc(3);
        chk("scheme_active", 38'h0, {37'h0, scheme_active});
        $display("test dynamic done");
        smp(1'b0);
        for (m = 0; m < 4; m++) begin
            comparator_event_enable = {46'h0, m[1:0]};
            adc_event_enable = {44'h0, m[1:0], 2'h0};
            shared_limit_event_enable = {22'h0, m[1:0]};
            smp(1'b1);
            chk("rise_flags", m[0] ? 38'h1000003 : 38'h0, event_flags);
            rd(1'b1);
            smp(1'b0);
            chk("fall_flags", m[1] ? 38'h1000003 : 38'h0, event_flags);
            rd(1'b1);
        end
        $display("test edges done");
        summarize();
    end

    initial begin
        cyc(20000);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
